/* hdl/rsc_reset_ctrl.sv */
// Reset sequencer, reset cause flags and factory options behind APB.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "rsc_consts.svh"
// ==========================================================
// Summary of operation
// - Always-on watchdog counts in every mode
// - Enabled watchdog halts in sleep modes; off disables
// - Normal mode cycle is 2/4/8/16 clocks
// - Slow mode cycle is low oscillator over four
// - Falling reset pin resets the whole system
// - General input mode: no reset, no pull-up
// - Security option blocks full ROM read-out
// - Detector reset threshold follows the option
// - Mid flag enabled only for mid/high option
// - High flag enabled only for high option
// - Reset on power, watchdog, brown-out, enabled pin
// - Reset holds registers, stops, clears counter
// - After release fetch starts at address zero
// - Cause bits: 00 wdt, 10 power, 11 pin
// - Low pin level recorded as external reset
// - Wait supply, then wait for pin high
// - Then initialise, warm up, then execute
// - Watchdog reset skips power and pin checks
// - Detector reset clears both low flags
// - Enabled flag shows one at or below level
module rsc_reset_ctrl #(
   parameter int               WARM_CLKS = `RSC_WARM_CLKS, // warm-up clocks
   parameter rsc_pkg::rsc_byte_t OPT_INIT  = `RSC_OPT_RESET // option default
) (
   input  wire logic        pclk,          // bus and oscillator clock
   input  wire logic        presetn,       // power-on reset, low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB write
   input  wire logic [11:0] paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic        supply_ok,     // supply stable, async
   input  wire logic        below_20,      // supply under 2.0V, async
   input  wire logic        below_24,      // supply at or under 2.4V
   input  wire logic        below_36,      // supply at or under 3.6V
   input  wire logic        reset_pin,     // shared pin level, async
   input  wire logic        wdt_overflow,  // watchdog overflow pulse
   input  wire logic        power_down,    // core in power-down
   input  wire logic        green_mode,    // core in green mode
   input  wire logic        slow_mode,     // core in slow mode
   input  wire logic        losc_tick,     // low oscillator edge pulse
   output logic             core_reset,    // core held in reset
   output logic             pc_zero,       // load address zero pulse
   output logic             icycle_tick,   // instruction cycle pulse
   output logic             wdt_count_en,  // watchdog may count
   output logic             rom_protect,   // block ROM read-out
   output logic             pin_pullup,    // pull-up on shared pin
   output logic             general_input_pin // pin as port bit
);
   localparam logic [15:0] WARM_N = 16'(WARM_CLKS - 1);
   localparam logic [9:0]  IX_FLG = `RSC_IDX_FLAGS;
   localparam logic [9:0]  IX_OPT = `RSC_IDX_OPTION;
   localparam logic [9:0]  IX_STA = `RSC_IDX_STATUS;

   rsc_pkg::rsc_state_e state_r;
   rsc_pkg::rsc_state_e state_nxt;
   rsc_pkg::rsc_byte_t  opt_r;
   logic [1:0]  cause_r;
   logic [2:0]  alu_r;
   logic        low24_r;
   logic        low36_r;
   logic [15:0] warm_r;
   logic [3:0]  div_r;
   logic [1:0]  slow_r;
   logic [4:0]  sync1_r;
   logic [4:0]  sync2_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        core_reset_r;
   logic        pc_zero_r;
   logic        icycle_r;
   logic        wdt_en_r;
   logic        rom_prot_r;
   logic        pullup_r;
   logic        gpin_r;

   // ==========================================================
   // Input synchronisers.
   // Only the second stage is read; comparators and the pin are async.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 5'h0_0;
         sync2_r <= 5'h0_0;
      end else begin
         sync1_r <= {reset_pin, below_36, below_24, below_20, supply_ok};
         sync2_r <= sync1_r;
      end
   end

   wire logic       s_supply = sync2_r[0];
   wire logic       s_b20    = sync2_r[1];
   wire logic       s_b24    = sync2_r[2];
   wire logic       s_b36    = sync2_r[3];
   wire logic       s_pin    = sync2_r[4];
   wire rsc_pkg::rsc_opt2_t o_wdt = opt_r[`RSC_O_WDT_LO +: 2];
   wire rsc_pkg::rsc_opt2_t o_div = opt_r[`RSC_O_DIV_LO +: 2];
   wire rsc_pkg::rsc_opt2_t o_lvd = opt_r[`RSC_O_LVD_LO +: 2];
   wire logic       o_pin    = opt_r[`RSC_O_PIN];

   // ==========================================================
   // Reset sources.
   logic lvd_trip;
   always_comb begin
      unique case (o_lvd)
         `RSC_LVD_LOW:  lvd_trip = s_b20;
         `RSC_LVD_MID:  lvd_trip = s_b20;
         `RSC_LVD_HIGH: lvd_trip = s_b24;
         `RSC_LVD_TOP:  lvd_trip = s_b36;
      endcase
   end
   // The pin counts only in reset-pin mode; a low level holds reset.
   wire logic pin_req  = o_pin & ~s_pin;
   wire logic pwr_bad  = ~s_supply | lvd_trip;
   // Code 3 is unused and behaves as off, the same as the count enable below.
   wire logic wdt_req  = wdt_overflow & ((o_wdt == `RSC_WDT_ON) |
                                         (o_wdt == `RSC_WDT_ALWAYS));

   // ==========================================================
   // Release sequence.
   always_comb begin
      state_nxt = state_r;
      if (pwr_bad) begin
         state_nxt = rsc_pkg::RSC_POWER;
      end else begin
         unique case (state_r)
            rsc_pkg::RSC_POWER: state_nxt = rsc_pkg::RSC_PIN;
            rsc_pkg::RSC_PIN: begin
               if (!pin_req) begin
                  state_nxt = rsc_pkg::RSC_INIT;
               end
            end
            rsc_pkg::RSC_INIT: state_nxt = rsc_pkg::RSC_WARM;
            rsc_pkg::RSC_WARM: begin
               if (pin_req) begin
                  state_nxt = rsc_pkg::RSC_PIN;
               end else if (warm_r == WARM_N) begin
                  state_nxt = rsc_pkg::RSC_RUN;
               end
            end
            rsc_pkg::RSC_RUN: begin
               if (pin_req) begin
                  state_nxt = rsc_pkg::RSC_PIN;
               end else if (wdt_req) begin
                  state_nxt = rsc_pkg::RSC_INIT;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= rsc_pkg::RSC_POWER;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Warm-up counter runs only in the warm state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warm_r <= 16'h0_000;
      end else if (state_r == rsc_pkg::RSC_WARM) begin
         warm_r <= warm_r + 16'h0_001;
      end else begin
         warm_r <= 16'h0_000;
      end
   end

   wire logic run_nxt = (state_nxt == rsc_pkg::RSC_RUN);
   wire logic run_now = (state_r == rsc_pkg::RSC_RUN);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_reset_r <= 1'b1;
         pc_zero_r    <= 1'b0;
      end else begin
         core_reset_r <= ~run_nxt;
         pc_zero_r    <= run_nxt & ~run_now;
      end
   end

   // ==========================================================
   // Instruction cycle strobe.
   wire logic [3:0] div_top = 4'((5'h0_2 << o_div) - 5'h0_1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r    <= 4'h0;
         slow_r   <= 2'h0;
         icycle_r <= 1'b0;
      end else if (!run_nxt) begin
         div_r    <= 4'h0;
         slow_r   <= 2'h0;
         icycle_r <= 1'b0;
      end else if (slow_mode) begin
         div_r    <= 4'h0;
         icycle_r <= 1'b0;
         if (losc_tick) begin
            slow_r   <= slow_r + 2'h1;
            icycle_r <= (slow_r == `RSC_SLOW_DIV);
         end
      end else begin
         slow_r   <= 2'h0;
         icycle_r <= (div_r == div_top);
         div_r    <= (div_r == div_top) ? 4'h0 : div_r + 4'h1;
      end
   end

   // ==========================================================
   // Option driven outputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_en_r   <= 1'b0;
         rom_prot_r <= 1'b1;
         pullup_r   <= 1'b0;
         gpin_r     <= 1'b0;
      end else begin
         wdt_en_r   <= (o_wdt == `RSC_WDT_ALWAYS) |
                       ((o_wdt == `RSC_WDT_ON) & ~power_down & ~green_mode);
         rom_prot_r <= opt_r[`RSC_O_SEC];
         pullup_r   <= o_pin;
         gpin_r     <= ~o_pin & s_pin;
      end
   end

   // ==========================================================
   // Low supply flags.
   wire logic lvd_rst = pwr_bad & s_supply;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low24_r <= 1'b0;
         low36_r <= 1'b0;
      end else if (lvd_rst) begin
         low24_r <= 1'b0;
         low36_r <= 1'b0;
      end else begin
         low24_r <= s_b24 & ((o_lvd == `RSC_LVD_MID) |
                             (o_lvd == `RSC_LVD_HIGH));
         low36_r <= s_b36 & (o_lvd == `RSC_LVD_HIGH);
      end
   end

   // ==========================================================
   // APB slave, zero wait states after the setup cycle.
   wire logic [9:0] idx  = paddr[11:2];
   wire logic       acc  = psel & penable & pready_r;
   wire logic       wr   = acc & pwrite;
   wire logic       hit  = (idx == IX_FLG) | (idx == IX_OPT) | (idx == IX_STA);
   wire logic       al   = (paddr[1:0] == 2'h0);

   // Hardware cause update wins over a software write in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_r <= `RSC_CAUSE_PWR;
      end else if (pwr_bad) begin
         cause_r <= `RSC_CAUSE_PWR;
      end else if (run_now & pin_req) begin
         cause_r <= `RSC_CAUSE_EXT;
      end else if (run_now & wdt_req) begin
         cause_r <= `RSC_CAUSE_WDT;
      end else if (wr & al & (idx == IX_FLG)) begin
         cause_r <= pwdata[`RSC_F_CAUSE_HI:`RSC_F_CAUSE_LO];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alu_r <= 3'h0;
      end else if (core_reset_r) begin
         alu_r <= 3'h0;
      end else if (wr & al & (idx == IX_FLG)) begin
         alu_r <= pwdata[`RSC_F_ALU_HI:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_r <= OPT_INIT;
      end else if (wr & al & (idx == IX_OPT)) begin
         opt_r <= pwdata[7:0];
      end
   end

   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      if (idx == IX_FLG) begin
         rd_val[`RSC_F_CAUSE_HI:`RSC_F_CAUSE_LO] = cause_r;
         rd_val[`RSC_F_LOW36] = low36_r;
         rd_val[`RSC_F_LOW24] = low24_r;
         rd_val[`RSC_F_ALU_HI:0] = alu_r;
      end else if (idx == IX_OPT) begin
         rd_val[7:0] = opt_r;
      end else if (idx == IX_STA) begin
         rd_val[2:0] = 3'(state_r);
         rd_val[3] = core_reset_r;
         rd_val[4] = gpin_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= psel & ~penable;
         pslverr_r <= psel & ~penable & ~(hit & al);
         prdata_r  <= (psel & ~penable & ~pwrite & hit & al) ? rd_val
                                                            : 32'h0000_0000;
      end
   end

   assign prdata            = prdata_r;
   assign pready            = pready_r;
   assign pslverr           = pslverr_r;
   assign core_reset        = core_reset_r;
   assign pc_zero           = pc_zero_r;
   assign icycle_tick       = icycle_r;
   assign wdt_count_en      = wdt_en_r;
   assign rom_protect       = rom_prot_r;
   assign pin_pullup        = pullup_r;
   assign general_input_pin = gpin_r;

   // ==========================================================
   // Checks.
   sequence run_with_pin_low;
      run_now & pin_req & ~pwr_bad;
   endsequence
   sequence wdt_in_run;
      run_now & wdt_req & ~pwr_bad & ~pin_req;
   endsequence

   pin_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      run_with_pin_low |=> state_r == rsc_pkg::RSC_PIN ##1 core_reset_r)
      else $error("pin low did not reset");
   pin_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
      run_with_pin_low |=> cause_r == `RSC_CAUSE_EXT)
      else $error("external cause not recorded");
   wdt_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
      wdt_in_run |=> state_r == rsc_pkg::RSC_INIT && cause_r == `RSC_CAUSE_WDT)
      else $error("watchdog reset took wrong path");
   pin_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == rsc_pkg::RSC_PIN && pin_req |=> state_r != rsc_pkg::RSC_INIT)
      else $error("left pin wait with pin low");
   warm_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_r == rsc_pkg::RSC_WARM) |-> warm_r == 16'h0_000)
      else $error("warm-up did not start from zero");
   pc_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(core_reset_r) |-> pc_zero_r)
      else $error("release without address zero");
   pwr_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
      pwr_bad |=> cause_r == `RSC_CAUSE_PWR ##1 core_reset_r)
      else $error("power cause or reset wrong");
   wdt_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      o_wdt == `RSC_WDT_OFF |=> !wdt_en_r)
      else $error("disabled watchdog counting");
   flag36_a: assert property (@(posedge pclk) disable iff (!presetn)
      o_lvd != `RSC_LVD_HIGH |=> !low36_r)
      else $error("high flag set in wrong option");
   alu_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      core_reset_r [*2] |-> alu_r == 3'h0)
      else $error("flags not held during reset");
endmodule // rsc_reset_ctrl

/* inc/rsc_consts.svh */
// Constants for the reset and option controller.
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
// ==========================================================
// Register indexes; the byte address is four times the index.
`define RSC_IDX_FLAGS   10'h086
`define RSC_IDX_OPTION  10'h088
`define RSC_IDX_STATUS  10'h089
// ==========================================================
// Processor flag fields.
`define RSC_F_CAUSE_HI  7
`define RSC_F_CAUSE_LO  6
`define RSC_F_LOW36     5
`define RSC_F_LOW24     4
`define RSC_F_ALU_HI    2
// ==========================================================
// Reset cause codes {upper, lower}.
`define RSC_CAUSE_WDT   2'h0
`define RSC_CAUSE_PWR   2'h2
`define RSC_CAUSE_EXT   2'h3
// ==========================================================
// Option register fields and codes.
`define RSC_O_WDT_LO    0
`define RSC_O_DIV_LO    2
`define RSC_O_PIN       4
`define RSC_O_SEC       5
`define RSC_O_LVD_LO    6
`define RSC_WDT_OFF     2'h0
`define RSC_WDT_ON      2'h1
`define RSC_WDT_ALWAYS  2'h2
`define RSC_LVD_LOW     2'h0
`define RSC_LVD_MID     2'h1
`define RSC_LVD_HIGH    2'h2
`define RSC_LVD_TOP     2'h3
`define RSC_OPT_RESET   8'h5_1
// ==========================================================
// Timing.
`define RSC_WARM_CLKS   16'h0_400
`define RSC_SLOW_DIV    2'h3
`endif

/* inc/rsc_pkg.sv */
// Types shared by the reset and option controller.
package rsc_pkg;
   typedef enum logic [2:0] {
      RSC_POWER,
      RSC_PIN,
      RSC_INIT,
      RSC_WARM,
      RSC_RUN
   } rsc_state_e;
   typedef logic [1:0] rsc_opt2_t;
   typedef logic [7:0] rsc_byte_t;
endpackage

/* tb/rsc_pin_ext.sv */
// Model of the outside reset circuit that drives the shared reset pin.
`timescale 1ns/1ns
// ==========================================================
// Pin driver
module rsc_pin_ext #(
   parameter int RISE_CLKS = 6          // slow release, like an RC ramp
) (
   input  wire logic pclk,              // clock
   input  wire logic hold_low,          // bench asks for a reset pulse
   output logic      reset_pin          // pin level, high = run
);
   int cnt;
   // The pin rises only some cycles after release, so the block must wait.
   always_ff @(posedge pclk) begin
      if (hold_low) begin
         cnt <= RISE_CLKS;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   assign reset_pin = !(hold_low || cnt > 0);
endmodule // rsc_pin_ext

/* tb/reset_and_option_control_tb.sv */
// Self-checking bench for the reset sequencer and option register.
`timescale 1ns/1ns
module reset_and_option_control_tb;
   localparam int          WARM  = 4;
   localparam logic [11:0] A_FLG = 12'h218;
   localparam logic [11:0] A_OPT = 12'h220;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, er, supply_ok = 0, below_20 = 0, below_24 = 0;
   logic        below_36 = 0, reset_pin, wdt_overflow = 0, power_down = 0;
   logic        green_mode = 0, slow_mode = 0, losc_tick = 0, losc_on = 0;
   logic        core_reset, pc_zero, icycle_tick, wdt_count_en, rom_protect;
   logic        pin_pullup, gin, hold_low = 1;
   int          err_total = 0, num_checks = 0, lc = 0;
   always #2 pclk = ~pclk;
   rsc_reset_ctrl #(.WARM_CLKS(WARM)) u_rsc_reset_ctrl (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
      .below_20(below_20), .below_24(below_24), .below_36(below_36),
      .reset_pin(reset_pin), .wdt_overflow(wdt_overflow), .power_down(power_down),
      .green_mode(green_mode), .slow_mode(slow_mode), .losc_tick(losc_tick),
      .core_reset(core_reset), .pc_zero(pc_zero), .icycle_tick(icycle_tick),
      .wdt_count_en(wdt_count_en), .rom_protect(rom_protect),
      .pin_pullup(pin_pullup), .general_input_pin(gin));
   rsc_pin_ext #(.RISE_CLKS(6)) u_rsc_pin_ext (.pclk(pclk), .hold_low(hold_low),
      .reset_pin(reset_pin));
   // Low oscillator stand-in: one tick every third clock.
   always @(posedge pclk) begin
      lc <= (lc == 2) ? 0 : lc + 1;
      losc_tick <= losc_on && lc == 2;
   end
   // ==========================================================
   // Shared tasks
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge pclk);
   endtask
   // Request is held until pready is seen high for the completing edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk(n, 1, "zero wait states");
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(0, a, '0);
      chk(rd, e, m);
   endtask
   task automatic wait_core(input logic lvl, input int lim, output int n);
      n = 0;
      while (core_reset !== lvl && n < lim) begin
         @(negedge pclk);
         n++;
      end
      chk(core_reset, lvl, "core reset level");
   endtask
   // Skips the settling after an option change, then times one tick gap.
   task automatic gap(output int g);
      int n;
      n = 0;
      cycles(40);
      while (icycle_tick !== 1'b1 && n < 100) begin
         @(negedge pclk);
         n++;
      end
      g = 0;
      do begin
         @(negedge pclk);
         g++;
      end while (icycle_tick !== 1'b1 && g < 100);
   endtask
   task automatic pulse_wdt();
      @(posedge pclk);
      wdt_overflow <= 1;
      @(posedge pclk);
      wdt_overflow <= 0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_power();
      int n;
      cycles(8);
      chk(core_reset, 1, "held before supply");
      @(posedge pclk);
      supply_ok <= 1;
      cycles(12);
      chk(core_reset, 1, "held while pin low");
      @(posedge pclk);
      hold_low <= 0;
      wait_core(0, 40, n);
      chk(n > 6, 1, "pin rise awaited");
      chk(pc_zero, 1, "fetch from zero");
      cycles(1);
      chk(pc_zero, 0, "zero pulse ends");
      chk(pin_pullup, 1, "pull-up in reset mode");
      rdchk(12'h224, 32'h0000_0004, "status shows run");
      rdchk(A_FLG, 32'h0000_0080, "power cause");
      rdchk(A_OPT, 32'h0000_0051, "option default");
      rdchk(12'h300, 32'h0000_0000, "unmapped read");
      chk(er, 1, "unmapped error");
      rdchk(12'h219, 32'h0000_0000, "unaligned read");
      chk(er, 1, "unaligned error");
      $display("power-up test done");
   endtask
   task automatic t_wdt();
      int n;
      pulse_wdt();
      wait_core(1, 4, n);
      wait_core(0, 20, n);
      chk(n >= WARM && n <= WARM + 3, 1, "warm-up span");
      chk(pc_zero, 1, "fetch from zero");
      rdchk(A_FLG, 32'h0000_0000, "watchdog cause");
      apb(1, A_OPT, 32'h0000_0050);
      pulse_wdt();
      cycles(6);
      chk(core_reset, 0, "overflow ignored when off");
      apb(1, A_OPT, 32'h0000_0051);
      $display("watchdog reset test done");
   endtask
   task automatic t_pin();
      int n;
      apb(1, A_FLG, 32'h0000_0087);
      rdchk(A_FLG, 32'h0000_0087, "alu bits writable");
      @(posedge pclk);
      hold_low <= 1;
      wait_core(1, 6, n);
      cycles(20);
      chk(core_reset, 1, "held while pin low");
      @(posedge pclk);
      hold_low <= 0;
      wait_core(0, 40, n);
      rdchk(A_FLG, 32'h0000_00C0, "pin cause, alu cleared");
      $display("pin reset test done");
   endtask
   task automatic t_input();
      apb(1, A_OPT, 32'h0000_0041);
      cycles(2);
      chk(pin_pullup, 0, "no pull-up");
      @(posedge pclk);
      hold_low <= 1;
      cycles(10);
      chk(core_reset, 0, "pin ignored");
      chk(gin, 0, "port reads low");
      @(posedge pclk);
      hold_low <= 0;
      cycles(12);
      chk(gin, 1, "port reads high");
      apb(1, A_OPT, 32'h0000_0051);
      $display("input mode test done");
   endtask
   task automatic t_rate();
      int g;
      for (int n = 0; n < 4; n++) begin
         apb(1, A_OPT, 32'h0000_0051 | (n << 2));
         gap(g);
         chk(g, 2 << n, "normal cycle length");
      end
      @(posedge pclk);
      slow_mode <= 1;
      losc_on <= 1;
      gap(g);
      chk(g, 12, "slow cycle length");
      @(posedge pclk);
      slow_mode <= 0;
      losc_on <= 0;
      $display("rate test done");
   endtask
   task automatic t_gate();
      for (int w = 0; w < 4; w++) begin
         for (int m = 0; m < 3; m++) begin
            apb(1, A_OPT, 32'h0000_0050 | w);
            @(posedge pclk);
            power_down <= (m == 1);
            green_mode <= (m == 2);
            cycles(3);
            chk(wdt_count_en, w == 2 || (w == 1 && m == 0), "count enable");
         end
      end
      @(posedge pclk);
      power_down <= 0;
      green_mode <= 0;
      apb(1, A_OPT, 32'h0000_0071);
      cycles(2);
      chk(rom_protect, 1, "protect on");
      apb(1, A_OPT, 32'h0000_0051);
      cycles(2);
      chk(rom_protect, 0, "protect off");
      $display("option test done");
   endtask
   task automatic t_lvd();
      int n;
      @(posedge pclk);
      below_24 <= 1;
      below_36 <= 1;
      apb(1, A_OPT, 32'h0000_0011);
      cycles(4);
      rdchk(A_FLG, 32'h0000_00C0, "low option flags");
      apb(1, A_OPT, 32'h0000_0051);
      cycles(4);
      rdchk(A_FLG, 32'h0000_00D0, "mid option flags");
      chk(core_reset, 0, "mid keeps 2.0V level");
      @(posedge pclk);
      below_24 <= 0;
      apb(1, A_OPT, 32'h0000_0091);
      cycles(4);
      rdchk(A_FLG, 32'h0000_00E0, "high option flags");
      @(posedge pclk);
      below_24 <= 1;
      wait_core(1, 8, n);
      rdchk(A_FLG, 32'h0000_0080, "flags cleared in detector reset");
      @(posedge pclk);
      below_24 <= 0;
      below_36 <= 0;
      wait_core(0, 40, n);
      rdchk(A_FLG, 32'h0000_0080, "detector cause, flags clear");
      apb(1, A_OPT, 32'h0000_00D1);
      @(posedge pclk);
      below_36 <= 1;
      wait_core(1, 8, n);
      @(posedge pclk);
      below_36 <= 0;
      wait_core(0, 40, n);
      apb(1, A_OPT, 32'h0000_0011);
      @(posedge pclk);
      below_20 <= 1;
      wait_core(1, 8, n);
      @(posedge pclk);
      below_20 <= 0;
      wait_core(0, 40, n);
      $display("detector test done");
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      t_power();
      t_wdt();
      t_pin();
      t_input();
      t_rate();
      t_gate();
      t_lvd();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      complete_run();
   end
endmodule // reset_and_option_control_tb
